// *** core/smp_pkg.sv ***
// Shared constants and types for the static memory pin configuration block
package smp_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned PD_PULSE_NS   = 200;
    localparam int unsigned PD_PULSE_CYC  =
        (PD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // APB register byte offsets
    localparam logic [7:0] OFS_WAKE     = 8'h00;
    localparam logic [7:0] OFS_SMCON    = 8'h04;
    localparam logic [7:0] OFS_ADDRPIN  = 8'h08;
    localparam logic [7:0] OFS_CTRLPIN  = 8'h0C;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_ACCCFG   = 8'h14;

    // Implemented bits of each writable register
    localparam logic [31:0] MASK_WAKE    = 32'h0000_0FFF;
    localparam logic [31:0] MASK_SMCON   = 32'h0000_FF81;
    localparam logic [31:0] MASK_ADDRPIN = 32'h80FF_FFFF;
    localparam logic [31:0] MASK_CTRLPIN = 32'h7703_33F3;
    localparam logic [31:0] MASK_ACCCFG  = 32'h0000_01FF;

    // Reset values
    localparam logic [31:0] RST_WAKE     = 32'h0000_00C8;
    localparam logic [31:0] RST_SMCON    = 32'h0000_0200;
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;

    // Field positions
    localparam int unsigned FLASH_POWERDOWN_CTL_BIT    = 0;
    localparam int unsigned W0_LSB      = 7;
    localparam int unsigned W1_LSB      = 10;
    localparam int unsigned W2_LSB      = 13;
    localparam int unsigned PINEN_BIT   = 31;
    localparam int unsigned RDYINV_LSB  = 28;
    localparam int unsigned RDYEN_LSB   = 24;
    localparam int unsigned RDYLVL_BIT  = 17;
    localparam int unsigned RPEN_BIT    = 16;
    localparam int unsigned WEEN_BIT    = 13;
    localparam int unsigned OEEN_BIT    = 12;
    localparam int unsigned BSEN_LSB    = 8;
    localparam int unsigned CSEN_LSB    = 4;
    localparam int unsigned DEN_LSB     = 0;
    localparam int unsigned ALT_BIT     = 8;
    localparam int unsigned STS_RDY_LSB = 4;

    // Data width codes
    localparam logic [2:0] WIDTH_8BIT  = 3'h4;
    localparam logic [2:0] WIDTH_16BIT = 3'h0;

    typedef enum logic [3:0] {
        PS_FORCE = 4'h1,
        PS_WAKE  = 4'h2,
        PS_RUN   = 4'h4,
        PS_OFF   = 4'h8
    } smp_pd_type;

endpackage : smp_pkg

// *** core/smp_rdy_if.sv ***
// Ready pin conditioning signals between the main block and the conditioner
`timescale 1ns/1ps
interface smp_rdy_if;
    logic [2:0] rawPin;
    logic [2:0] invert;
    logic [2:0] enable;
    logic       levelSense;
    logic [2:0] readyHit;
    modport main (output rawPin, output invert, output enable,
                  output levelSense, input readyHit);
    modport cond (input rawPin, input invert, input enable,
                  input levelSense, output readyHit);
endinterface : smp_rdy_if

// *** core/smp_wake_timer.sv ***
// Down counter that times the flash wake-up delay
`timescale 1ns/1ps
module smp_wake_timer
    import smp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        load,
    input  wire logic [11:0] loadVal,
    output logic             busy
);
    typedef struct packed {
        logic [11:0] cnt;
    } smp_wt_type;

    smp_wt_type q;
    smp_wt_type d;

    always_comb begin
        d = q;
        if (load) begin
            d.cnt = loadVal;
        end else if (q.cnt != 12'h000) begin
            d.cnt = q.cnt - 12'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign busy = (q.cnt != 12'h000);
endmodule : smp_wake_timer

// *** core/smp_ready_cond.sv ***
// Ready pin inversion and level or edge detection
`timescale 1ns/1ps
module smp_ready_cond
    import smp_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    smp_rdy_if.cond   rdy
);
    typedef struct packed {
        logic [2:0] prev;
    } smp_rc_type;

    smp_rc_type q;
    smp_rc_type d;
    logic [2:0] seen;

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_pin
            assign seen[i] = rdy.rawPin[i] ^ rdy.invert[i];
            // Edge mode catches only the rising side of the corrected pin
            assign rdy.readyHit[i] = rdy.enable[i] &
                (rdy.levelSense ? seen[i]
                                : (seen[i] & ~q.prev[i]));
        end
    endgenerate

    always_comb begin
        d = q;
        d.prev = seen;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : smp_ready_cond

// *** core/smp_pin_config.sv ***
// Static memory pin configuration: registers, flash power-down, pin owners
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module smp_pin_config
    import smp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        accReq,
    input  wire logic [1:0]  accCs,
    output logic             accGrant,
    output logic             accWide8,
    output logic [1:0]       accSet,
    output logic             flashPowerdownN,
    input  wire logic [2:0]  readyInput,
    output logic [2:0]       readyHit,
    output logic [23:0]      addrPinOwn,
    output logic [1:0]       dataPinOwn,
    output logic [3:0]       csPinOwn,
    output logic [1:0]       bsPinOwn,
    output logic             oePinOwn,
    output logic             wePinOwn,
    output logic             rpPinOwn,
    output logic [2:0]       readyPinOwn
);
    typedef struct packed {
        smp_pd_type  pd;
        logic [3:0]  pulseCnt;
        logic [31:0] wake;
        logic [31:0] smcon;
        logic [31:0] addrPin;
        logic [31:0] ctrlPin;
        logic [31:0] accCfg;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        grant;
        logic        wide8;
        logic [1:0]  set;
        logic        pdN;
        logic [2:0]  readyHit;
        logic [23:0] addrOwn;
        logic [1:0]  dataOwn;
        logic [3:0]  csOwn;
        logic [1:0]  bsOwn;
        logic        oeOwn;
        logic        weOwn;
        logic        rpOwn;
        logic [2:0]  rdyOwn;
    } smp_state_type;

    smp_state_type q;
    smp_state_type d;

    logic        access;
    logic        hit;
    logic        wrEn;
    logic [31:0] rdata;
    logic        wakeLoad;
    logic        wakeBusy;
    logic        pinsOn;
    logic [1:0]  selSet;
    logic [2:0]  selWidth;

    smp_rdy_if rdyBus ();

    smp_wake_timer u_wake (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .load    (wakeLoad),
        .loadVal (q.wake[11:0]),
        .busy    (wakeBusy)
    );

    smp_ready_cond u_rdy (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .rdy     (rdyBus.cond)
    );

    assign rdyBus.rawPin     = readyInput;
    assign rdyBus.invert     = q.ctrlPin[RDYINV_LSB +: 3];
    assign rdyBus.enable     = q.rdyOwn;
    assign rdyBus.levelSense = q.ctrlPin[RDYLVL_BIT];

    // Register read decode; reserved bits are masked here on read as well as at write time
    always_comb begin
        hit   = 1'b1;
        rdata = RST_ZERO;
        if (paddr == OFS_WAKE) begin
            rdata = q.wake & MASK_WAKE;
        end else if (paddr == OFS_SMCON) begin
            rdata = q.smcon & MASK_SMCON;
        end else if (paddr == OFS_ADDRPIN) begin
            rdata = q.addrPin & MASK_ADDRPIN;
        end else if (paddr == OFS_CTRLPIN) begin
            rdata = q.ctrlPin & MASK_CTRLPIN;
        end else if (paddr == OFS_STATUS) begin
            rdata = {25'h000_0000, q.readyHit, wakeBusy,
                     (q.pd == PS_FORCE), q.pdN, (q.pd == PS_RUN)};
        end else if (paddr == OFS_ACCCFG) begin
            rdata = q.accCfg & MASK_ACCCFG;
        end else begin
            hit = 1'b0;
        end
    end

    assign access = psel & penable;
    assign wrEn   = access & q.pready & pwrite & hit;

    always_comb begin
        d         = q;
        wakeLoad  = 1'b0;
        selSet    = 2'h0;
        selWidth  = WIDTH_16BIT;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        d.grant   = 1'b0;

        // One wait state so that read data comes from a flip-flop
        if (access & ~q.pready) begin
            d.pready  = 1'b1;
            d.pslverr = ~hit;
            d.prdata  = pwrite ? RST_ZERO : rdata;
        end

        if (wrEn) begin
            if (paddr == OFS_WAKE) begin
                d.wake = pwdata & MASK_WAKE;
            end else if (paddr == OFS_SMCON) begin
                d.smcon = pwdata & MASK_SMCON;
            end else if (paddr == OFS_ADDRPIN) begin
                d.addrPin = pwdata & MASK_ADDRPIN;
            end else if (paddr == OFS_CTRLPIN) begin
                d.ctrlPin = pwdata & MASK_CTRLPIN;
            end else if (paddr == OFS_ACCCFG) begin
                d.accCfg = pwdata & MASK_ACCCFG;
            end
        end

        // Power-down sequencer; the hardware set wins over a software clear
        case (q.pd)
            PS_FORCE: begin
                d.smcon[FLASH_POWERDOWN_CTL_BIT] = 1'b0;
                if (q.pulseCnt <= 4'h1) begin
                    d.smcon[FLASH_POWERDOWN_CTL_BIT] = 1'b1;
                    wakeLoad = 1'b1;
                    d.pd = PS_WAKE;
                end else begin
                    d.pulseCnt = q.pulseCnt - 4'h1;
                end
            end
            PS_WAKE: begin
                if (!d.smcon[FLASH_POWERDOWN_CTL_BIT]) begin
                    d.pd = PS_OFF;
                end else if (!wakeBusy) begin
                    d.pd = PS_RUN;
                end
            end
            PS_RUN: begin
                if (!d.smcon[FLASH_POWERDOWN_CTL_BIT]) begin
                    d.pd = PS_OFF;
                end
            end
            PS_OFF: begin
                // Leaving power-down is a flash reset, so the delay reruns
                if (d.smcon[FLASH_POWERDOWN_CTL_BIT]) begin
                    wakeLoad = 1'b1;
                    d.pd = PS_WAKE;
                end
            end
            default: begin
                d.pd = PS_FORCE;
            end
        endcase
        d.pdN = d.smcon[FLASH_POWERDOWN_CTL_BIT];

        // Set 3 is reserved and falls back to set 0
        selSet = d.accCfg[{accCs, 1'b0} +: 2];
        if (selSet == 2'h1) begin
            selWidth = d.smcon[W1_LSB +: 3];
        end else if (selSet == 2'h2) begin
            selWidth = d.smcon[W2_LSB +: 3];
        end else begin
            selSet   = 2'h0;
            selWidth = d.smcon[W0_LSB +: 3];
        end
        if (accReq & (q.pd == PS_RUN) & (d.pd == PS_RUN) & ~q.grant) begin
            d.grant = 1'b1;
            d.set   = selSet;
            d.wide8 = (selWidth == WIDTH_8BIT);
        end

        d.readyHit = rdyBus.readyHit;

        // Pin ownership
        pinsOn    = d.addrPin[PINEN_BIT] & ~d.accCfg[ALT_BIT];
        d.addrOwn = pinsOn ? d.addrPin[23:0] : 24'h00_0000;
        d.dataOwn = pinsOn ? d.ctrlPin[DEN_LSB +: 2] : 2'h0;
        d.csOwn   = pinsOn ? d.ctrlPin[CSEN_LSB +: 4] : 4'h0;
        d.bsOwn   = pinsOn ? d.ctrlPin[BSEN_LSB +: 2] : 2'h0;
        d.oeOwn   = pinsOn & d.ctrlPin[OEEN_BIT];
        d.weOwn   = pinsOn & d.ctrlPin[WEEN_BIT];
        d.rpOwn   = pinsOn & d.ctrlPin[RPEN_BIT];
        d.rdyOwn  = pinsOn ? d.ctrlPin[RDYEN_LSB +: 3] : 3'h0;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q          <= '0;
            q.pd       <= PS_FORCE;
            q.pulseCnt <= 4'(PD_PULSE_CYC);
            q.wake     <= RST_WAKE;
            q.smcon    <= RST_SMCON;
        end else begin
            q <= d;
        end
    end

    assign prdata          = q.prdata;
    assign pready          = q.pready;
    assign pslverr         = q.pslverr;
    assign accGrant        = q.grant;
    assign accWide8        = q.wide8;
    assign accSet          = q.set;
    assign flashPowerdownN = q.pdN;
    assign readyHit        = q.readyHit;
    assign addrPinOwn      = q.addrOwn;
    assign dataPinOwn      = q.dataOwn;
    assign csPinOwn        = q.csOwn;
    assign bsPinOwn        = q.bsOwn;
    assign oePinOwn        = q.oeOwn;
    assign wePinOwn        = q.weOwn;
    assign rpPinOwn        = q.rpOwn;
    assign readyPinOwn     = q.rdyOwn;

    // Checks
    sequence s_force_end;
        (q.pd == PS_FORCE) && (q.pulseCnt <= 4'h1);
    endsequence

    sequence s_wake_start;
        (q.pd == PS_WAKE) && wakeBusy;
    endsequence

    property p_wake_blocks;
        @(posedge clk_sys) disable iff (!rst_n)
        s_wake_start |=> !accGrant;
    endproperty
    a_wake_blocks: assert property (p_wake_blocks)
        else $error("grant during flash wake delay");

    property p_width_set0;
        @(posedge clk_sys) disable iff (!rst_n)
        accGrant && (accSet == 2'h0) |->
            accWide8 == (q.smcon[W0_LSB +: 3] == WIDTH_8BIT);
    endproperty
    a_width_set0: assert property (p_width_set0)
        else $error("set 0 width code not applied");

    property p_force_release;
        @(posedge clk_sys) disable iff (!rst_n)
        s_force_end |=> q.smcon[FLASH_POWERDOWN_CTL_BIT] && flashPowerdownN
                        ##1 (q.pd != PS_FORCE);
    endproperty
    a_force_release: assert property (p_force_release)
        else $error("power-down control not set after forced pulse");

    property p_force_low;
        @(posedge clk_sys) disable iff (!rst_n)
        (q.pd == PS_FORCE) |-> !flashPowerdownN && !accGrant;
    endproperty
    a_force_low: assert property (p_force_low)
        else $error("flash not held in power-down after reset");

    property p_clear_forces_pd;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(q.smcon[FLASH_POWERDOWN_CTL_BIT]) |-> !flashPowerdownN ##1 !accGrant;
    endproperty
    a_clear_forces_pd: assert property (p_clear_forces_pd)
        else $error("clearing control bit did not force power-down");

    property p_master_off;
        @(posedge clk_sys) disable iff (!rst_n)
        !q.addrPin[PINEN_BIT] |-> (addrPinOwn == 24'h00_0000) &&
            (csPinOwn == 4'h0) && !wePinOwn && !oePinOwn;
    endproperty
    a_master_off: assert property (p_master_off)
        else $error("pins owned while master enable is clear");

    property p_addr_follow;
        @(posedge clk_sys) disable iff (!rst_n)
        q.addrPin[PINEN_BIT] && !q.accCfg[ALT_BIT] |->
            addrPinOwn == q.addrPin[23:0];
    endproperty
    a_addr_follow: assert property (p_addr_follow)
        else $error("address pin owners differ from enables");

    property p_alt_frees;
        @(posedge clk_sys) disable iff (!rst_n)
        q.accCfg[ALT_BIT] |-> (addrPinOwn == 24'h00_0000) &&
            (dataPinOwn == 2'h0) && (readyPinOwn == 3'h0) && !rpPinOwn;
    endproperty
    a_alt_frees: assert property (p_alt_frees)
        else $error("pins owned in alternate interface mode");

    property p_smcon_upper_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        pready && !pslverr && (paddr == OFS_SMCON) && !pwrite |->
            prdata[31:16] == 16'h0000;
    endproperty
    a_smcon_upper_zero: assert property (p_smcon_upper_zero)
        else $error("upper control register bits read nonzero");

    property p_grant_follows_req;
        @(posedge clk_sys) disable iff (!rst_n)
        accGrant |-> $past(accReq) && (accSet != 2'h3) ##1 !accGrant;
    endproperty
    a_grant_follows_req: assert property (p_grant_follows_req)
        else $error("grant without request or bad set");

endmodule : smp_pin_config

// *** dv/smp_flash_model.sv ***
// Behavioural external flash: ready handshake and power-down watch
`timescale 1ns/1ps
module smp_flash_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       powerdownN,
    input  wire logic       grant,
    input  wire logic [3:0] waitCycles,
    output logic [2:0]      readyOut,
    output logic [7:0]      pdViolations
);
    logic [3:0] busyCnt_q;

    // Busy right after each access, then ready again
    assign readyOut = (busyCnt_q == 4'h0) ? 3'h7 : 3'h0;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busyCnt_q    <= 4'h0;
            pdViolations <= 8'h00;
        end else begin
            if (grant) begin
                busyCnt_q <= waitCycles;
            end else if (busyCnt_q != 4'h0) begin
                busyCnt_q <= busyCnt_q - 4'h1;
            end
            // An access while powerdownN is low (flash held in power-down) is a device fault
            if (grant && !powerdownN) begin
                pdViolations <= pdViolations + 8'h01;
            end
        end
    end
endmodule : smp_flash_model

// *** dv/tb_smp_pin_config.sv ***
// Self-checking testbench for the static memory pin configuration block
`timescale 1ns/1ps
module tb_smp_pin_config import smp_pkg::*; ;
    logic clk_sys = 1'b0, rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, accGrant, accWide8, flashPowerdownN;
    logic        accReq = 1'b1;
    logic [1:0]  accCs = 2'h0;
    logic [1:0]  accSet, dataPinOwn, bsPinOwn;
    logic [2:0]  readyInput, readyHit, readyPinOwn;
    logic [23:0] addrPinOwn;
    logic [3:0]  csPinOwn, waitCycles = 4'h1;
    logic        oePinOwn, wePinOwn, rpPinOwn;
    logic [7:0]  pdViolations;
    int failures = 0;
    int samples_checked = 0;

    smp_pin_config u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .accReq(accReq), .accCs(accCs), .accGrant(accGrant),
        .accWide8(accWide8), .accSet(accSet),
        .flashPowerdownN(flashPowerdownN), .readyInput(readyInput),
        .readyHit(readyHit), .addrPinOwn(addrPinOwn),
        .dataPinOwn(dataPinOwn), .csPinOwn(csPinOwn), .bsPinOwn(bsPinOwn),
        .oePinOwn(oePinOwn), .wePinOwn(wePinOwn), .rpPinOwn(rpPinOwn),
        .readyPinOwn(readyPinOwn));

    smp_flash_model u_mem (.clk_sys(clk_sys), .rst_n(rst_n),
        .powerdownN(flashPowerdownN), .grant(accGrant),
        .waitCycles(waitCycles), .readyOut(readyInput),
        .pdViolations(pdViolations));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected at %0t: got %h range %h..%h",
                     $time, got, lo, hi);
        end
    endtask : chk_rng

    // Master holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk(32'h0000_0bad, 32'h0000_0000);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic experr);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0000_0000, rd, er);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, experr});
    endtask : rd_chk

    // Count edges until a signal reads high, bounded
    task automatic wait_hi(ref logic s, output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (s !== 1'b1 && n < 600);
        if (s !== 1'b1) chk(32'h0000_0bad, 32'h0000_0000);
    endtask : wait_hi

    task automatic t_reset;
        int n;
        wait_hi(flashPowerdownN, n);
        chk_rng(n, PD_PULSE_CYC, PD_PULSE_CYC + 2);
        wait_hi(accGrant, n);
        chk_rng(n, 200, 204);
        rd_chk(OFS_SMCON, RST_SMCON | 32'h0000_0001, 1'b0);
        rd_chk(OFS_WAKE, RST_WAKE, 1'b0);
        rd_chk(OFS_ADDRPIN, RST_ZERO, 1'b0);
        rd_chk(OFS_CTRLPIN, RST_ZERO, 1'b0);
        rd_chk(8'h18, RST_ZERO, 1'b1);
    endtask : t_reset

    // A reset in mid-run must rerun the forced power-down and the wake wait
    task automatic t_rereset;
        int n;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_hi(flashPowerdownN, n);
        chk_rng(n, PD_PULSE_CYC, PD_PULSE_CYC + 2);
        wait_hi(accGrant, n);
        chk_rng(n, 200, 204);
        rd_chk(OFS_SMCON, RST_SMCON | 32'h0000_0001, 1'b0);
        rd_chk(OFS_ADDRPIN, RST_ZERO, 1'b0);
    endtask : t_rereset

    task automatic t_masks;
        logic [7:0]  ofs [5] = '{OFS_WAKE, OFS_SMCON, OFS_ADDRPIN,
                                 OFS_CTRLPIN, OFS_ACCCFG};
        logic [31:0] msk [5] = '{MASK_WAKE, MASK_SMCON, MASK_ADDRPIN,
                                 MASK_CTRLPIN, MASK_ACCCFG};
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 32'hFFFF_FFFF);
            rd_chk(ofs[i], msk[i], 1'b0);
        end
        wr(OFS_ACCCFG, 32'h0000_0000);
        wr(OFS_SMCON, RST_SMCON | 32'h0000_0001);
    endtask : t_masks

    task automatic chk_pins(input logic [23:0] a, input logic [13:0] c);
        repeat (2) @(posedge clk_sys);
        chk({8'h00, addrPinOwn}, {8'h00, a});
        chk({18'h0, dataPinOwn, csPinOwn, bsPinOwn, oePinOwn, wePinOwn,
             rpPinOwn, readyPinOwn}, {18'h0, c});
    endtask : chk_pins

    task automatic t_pins;
        wr(OFS_CTRLPIN, MASK_CTRLPIN);
        wr(OFS_ADDRPIN, 32'h0000_00A5);
        chk_pins(24'h00_0000, 14'h0000);
        wr(OFS_ADDRPIN, 32'h80A5_0F0F);
        chk_pins(24'hA5_0F0F, 14'h3FFF);
        wr(OFS_CTRLPIN, 32'h0000_0002);
        chk_pins(24'hA5_0F0F, 14'h2000);
        wr(OFS_ACCCFG, 32'h0000_0100);
        chk_pins(24'h00_0000, 14'h0000);
        wr(OFS_ACCCFG, 32'h0000_0000);
    endtask : t_pins

    task automatic t_width;
        logic [1:0] eset [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
        logic       e8 [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        int n;
        // Set 0 is 8-bit, set 1 is 16-bit, set 2 holds a reserved code
        wr(OFS_ACCCFG, 32'h0000_0024);
        wr(OFS_SMCON, 32'h0000_A201);
        for (int cs = 0; cs < 4; cs++) begin
            accCs <= cs[1:0];
            wait_hi(accGrant, n);
            wait_hi(accGrant, n);
            chk({30'h0, accSet}, {30'h0, eset[cs]});
            chk({31'h0, accWide8}, {31'h0, e8[cs]});
        end
    endtask : t_width

    task automatic t_wake;
        int n;
        wr(OFS_WAKE, 32'h0000_000A);
        wr(OFS_SMCON, 32'h0000_A200);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, flashPowerdownN}, 32'h0000_0000);
        repeat (20) @(posedge clk_sys);
        chk({31'h0, flashPowerdownN}, 32'h0000_0000);
        wr(OFS_SMCON, 32'h0000_A201);
        if (flashPowerdownN !== 1'b1) wait_hi(flashPowerdownN, n);
        wait_hi(accGrant, n);
        chk_rng(n, 10, 14);
        chk({24'h0, pdViolations}, 32'h0000_0000);
        rd_chk(OFS_STATUS, 32'h0000_0003, 1'b0);
    endtask : t_wake

    task automatic t_ready;
        logic [2:0] prevIn;
        logic [2:0] prevHit;
        int pulses;
        pulses = 0;
        waitCycles <= 4'h3;
        wr(OFS_ADDRPIN, 32'h8000_0000);
        wr(OFS_CTRLPIN, 32'h2702_0000);
        @(posedge clk_sys);
        prevIn = readyInput;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk_sys);
            chk({29'h0, readyHit}, {29'h0, prevIn ^ 3'h2});
            prevIn = readyInput;
            // Sparse requests let the model drop and raise its ready pins
            accReq <= (i % 8 == 0);
        end
        // Edge mode: single-cycle pulses only
        wr(OFS_CTRLPIN, 32'h0700_0000);
        @(posedge clk_sys);
        prevHit = 3'h0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            chk({29'h0, readyHit & prevHit}, 32'h0000_0000);
            if (readyHit[0] === 1'b1) pulses++;
            prevHit = readyHit;
            accReq <= (i % 8 == 0);
        end
        chk_rng(pulses, 1, 20);
    endtask : t_ready

    initial begin
        #(40 * 20000);
        failures++;
        $display("unexpected at %0t: got %h expected %h", $time, 0, 1);
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_masks();
        t_pins();
        t_width();
        t_rereset();
        t_wake();
        t_ready();
        chk({24'h0, pdViolations}, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : tb_smp_pin_config
